// ===== rtl/cmcrc_pkg.sv
// constants, types and crc function for the configuration memory crc checker
// How it works
// - while configuring, check each frame crc; stop on mismatch or after last frame.
// - at configuration end, store whole-stream 32-bit crc in reference register.
// - in user mode, rescan configuration cells continuously and compare against reference.
// - user-mode checking runs until the reconfiguration request is driven low.
// - only configuration cells are scanned; memory blocks and io state excluded.
// - one 32-bit crc using the ieee 802 crc-32 generator polynomial.
// - soft error output is 0 for zero signature, 1 otherwise.
// - load instruction puts reference register between tdi and tdo; tester shifts.
// - reference load instruction only accepted while in user mode.
// - frame crc mismatch drives the active-low configuration status low.
package cmcrc_pkg;

    typedef enum logic [1:0] {
        CMCRC_CONFIG = 2'b00,
        CMCRC_USER   = 2'b01,
        CMCRC_FAIL   = 2'b10
    } cmcrc_mode_t;

    localparam int          CELL_WORDS_DEFAULT = 1024;
    localparam int          FRAME_CRC_W        = 16;
    localparam logic [31:0] CRC_POLY           = 32'h04c11db7;
    localparam logic [31:0] CRC_INIT           = 32'hffffffff;
    localparam logic [31:0] SIG_CLEAR          = 32'h00000000;
    localparam logic [31:0] REF_RESET          = 32'h00000000;
    localparam logic [31:0] CELL_RESET         = 32'h00000000;
    // positions in the pin synchroniser vector
    localparam int          SY_TCK             = 0;
    localparam int          SY_TDI             = 1;
    localparam int          SY_SHIFT           = 2;
    localparam int          SY_INSTR           = 3;
    localparam int          SY_RECONF          = 4;
    localparam int          SY_W               = 5;
    // reconfiguration request idles high, everything else low
    localparam logic [4:0]  SY_RESET           = 5'h10;

    // msb-first crc-32 over one word, no reflection, no final xor
    function automatic logic [31:0] crc32_word(input logic [31:0] crc,
                                               input logic [31:0] data);
        logic [31:0] c;
        logic        fb;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            fb = c[31] ^ data[i];
            c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
        end
        return c;
    endfunction

endpackage

// ===== rtl/cmcrc_cell_if.sv
// carrier between the checker and its configuration cell store
`timescale 1ns/1ns
interface cmcrc_cell_if #(
    parameter int ADDR_W = 10
);
    logic              wrEn;
    logic [ADDR_W-1:0] wrAddr;
    logic [31:0]       wrData;
    logic [ADDR_W-1:0] rdAddr;
    logic [31:0]       rdData;

    modport ctrl (
        output wrEn,
        output wrAddr,
        output wrData,
        output rdAddr,
        input  rdData
    );
    modport store (
        input  wrEn,
        input  wrAddr,
        input  wrData,
        input  rdAddr,
        output rdData
    );
endinterface

// ===== rtl/cmcrc_cell_mem.sv
// configuration cell store with one write port and a registered read port
`timescale 1ns/1ns
module cmcrc_cell_mem #(
    parameter int DEPTH  = cmcrc_pkg::CELL_WORDS_DEFAULT,
    parameter int ADDR_W = $clog2(DEPTH)
) (
    input wire logic    core_clk,
    input wire logic    rst,
    cmcrc_cell_if.store cells
);
    typedef struct packed {
        logic [31:0] rdData;
    } cmcrc_mem_state_t;

    logic [31:0]      cellArray [DEPTH];
    cmcrc_mem_state_t s;
    cmcrc_mem_state_t next_s;

    // only configuration cells live here; block ram and io state never enter the scan
    always_ff @(posedge core_clk) begin
        if (cells.wrEn) begin
            cellArray[cells.wrAddr] <= cells.wrData;
        end
    end

    always_comb begin
        next_s = s;
        next_s.rdData = cellArray[cells.rdAddr];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '{rdData: cmcrc_pkg::CELL_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign cells.rdData = s.rdData;
endmodule

// ===== rtl/cmcrc_checker.sv
// configuration memory crc checker: frame checks, reference store, user-mode scan
`timescale 1ns/1ns
module cmcrc_checker #(
    parameter int CELL_WORDS = cmcrc_pkg::CELL_WORDS_DEFAULT,
    parameter int ADDR_W     = $clog2(CELL_WORDS)
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        cfgValid,
    input  wire logic [31:0] cfgData,
    input  wire logic        cfgFrameEnd,
    input  wire logic        cfgStreamEnd,
    input  wire logic        reconfigRequestN,
    input  wire logic        loadReferenceInstr,
    input  wire logic        jtagTck,
    input  wire logic        jtagTdi,
    input  wire logic        jtagShiftDr,
    output logic             jtagTdo,
    output logic             jtagTdoOe,
    output logic             configStatusN,
    output logic             userMode,
    output logic             softError,
    output logic [31:0]      signature
);
    typedef struct packed {
        cmcrc_pkg::cmcrc_mode_t      mode;
        logic [ADDR_W-1:0]           wrAddr;
        logic [ADDR_W-1:0]           lastAddr;
        logic [ADDR_W-1:0]           rdAddr;
        logic                        rdPend;
        logic                        rdLast;
        logic [31:0]                 frameCrc;
        logic [31:0]                 scanCrc;
        logic [31:0]                 reference;
        logic [31:0]                 signature;
        logic                        softError;
        logic                        statusN;
        logic                        tdo;
        logic [cmcrc_pkg::SY_W-1:0]  sy1;
        logic [cmcrc_pkg::SY_W-1:0]  sy2;
        logic [cmcrc_pkg::SY_W-1:0]  sy3;
        logic [cmcrc_pkg::SY_W-1:0]  lvl;
    } cmcrc_state_t;

    cmcrc_state_t s;
    cmcrc_state_t next_s;
    logic         tckRise;
    logic         shiftEn;
    logic         passEnd;
    logic         frameBad;
    logic         cfgTake;
    logic [31:0]  scanNext;

    cmcrc_cell_if #(.ADDR_W(ADDR_W)) cells ();

    cmcrc_cell_mem #(
        .DEPTH  (CELL_WORDS),
        .ADDR_W (ADDR_W)
    ) u_cells (
        .core_clk (core_clk),
        .rst      (rst),
        .cells    (cells.store)
    );

    // a tck edge counts only once the second and third stages agree
    assign tckRise  = ~s.lvl[cmcrc_pkg::SY_TCK] & s.sy2[cmcrc_pkg::SY_TCK]
                    & s.sy3[cmcrc_pkg::SY_TCK];
    // outside user mode the load instruction is simply ignored
    assign shiftEn  = (s.mode == cmcrc_pkg::CMCRC_USER) & s.lvl[cmcrc_pkg::SY_INSTR]
                    & s.lvl[cmcrc_pkg::SY_SHIFT];
    assign passEnd  = s.rdPend & s.rdLast;
    assign scanNext = cmcrc_pkg::crc32_word(s.scanCrc, cells.rdData);
    assign cfgTake  = cfgValid & (s.mode == cmcrc_pkg::CMCRC_CONFIG);
    assign frameBad = s.frameCrc[cmcrc_pkg::FRAME_CRC_W-1:0]
                   != cfgData[cmcrc_pkg::FRAME_CRC_W-1:0];

    assign cells.wrEn   = cfgTake & ~cfgFrameEnd & ~cfgStreamEnd & s.lvl[cmcrc_pkg::SY_RECONF];
    assign cells.wrAddr = s.wrAddr;
    assign cells.wrData = cfgData;
    assign cells.rdAddr = s.rdAddr;

    always_comb begin
        next_s = s;
        next_s.sy1 = {reconfigRequestN, loadReferenceInstr, jtagShiftDr, jtagTdi, jtagTck};
        next_s.sy2 = s.sy1;
        next_s.sy3 = s.sy2;
        // a level moves once stages two and three agree, otherwise it holds
        next_s.lvl = ((s.sy2 ^ s.sy3) & s.lvl) | (~(s.sy2 ^ s.sy3) & s.sy2);
        unique case (s.mode)
            cmcrc_pkg::CMCRC_CONFIG: begin
                if (cfgValid) begin
                    if (cfgStreamEnd) begin
                        next_s.reference = cfgData;
                        next_s.mode      = cmcrc_pkg::CMCRC_USER;
                        // a full store wraps the write pointer, so zero means every cell
                        next_s.lastAddr  = (s.wrAddr == '0) ? ADDR_W'(CELL_WORDS - 1)
                                                            : ADDR_W'(s.wrAddr - 1'b1);
                        next_s.rdAddr    = '0;
                        next_s.rdPend    = 1'b0;
                        next_s.scanCrc   = cmcrc_pkg::CRC_INIT;
                    end else if (cfgFrameEnd) begin
                        next_s.frameCrc = cmcrc_pkg::CRC_INIT;
                        if (frameBad) begin
                            next_s.mode    = cmcrc_pkg::CMCRC_FAIL;
                            next_s.statusN = 1'b0;
                        end
                    end else begin
                        next_s.frameCrc = cmcrc_pkg::crc32_word(s.frameCrc, cfgData);
                        next_s.wrAddr   = (s.wrAddr == ADDR_W'(CELL_WORDS - 1)) ? '0
                                        : ADDR_W'(s.wrAddr + 1'b1);
                    end
                end
            end
            cmcrc_pkg::CMCRC_USER: begin
                // free-running scan, no trigger needed
                next_s.rdPend = 1'b1;
                next_s.rdLast = (s.rdAddr == s.lastAddr);
                next_s.rdAddr = (s.rdAddr == s.lastAddr) ? '0 : ADDR_W'(s.rdAddr + 1'b1);
                if (s.rdPend) begin
                    next_s.scanCrc = passEnd ? cmcrc_pkg::CRC_INIT : scanNext;
                end
                // flag moves only at pass end, so a half-done pass never glitches it
                if (passEnd) begin
                    next_s.signature = scanNext ^ s.reference;
                    next_s.softError = (scanNext ^ s.reference) != cmcrc_pkg::SIG_CLEAR;
                end
                // reference sits in the scan path, lsb out first
                if (tckRise && shiftEn) begin
                    next_s.reference = {s.lvl[cmcrc_pkg::SY_TDI], s.reference[31:1]};
                end
            end
            cmcrc_pkg::CMCRC_FAIL: begin
                next_s.mode = cmcrc_pkg::CMCRC_FAIL;
            end
            default: begin
                next_s.mode = cmcrc_pkg::CMCRC_CONFIG;
            end
        endcase
        // only a reconfiguration request ends checking
        if (!s.lvl[cmcrc_pkg::SY_RECONF]) begin
            next_s.mode      = cmcrc_pkg::CMCRC_CONFIG;
            next_s.wrAddr    = '0;
            next_s.rdAddr    = '0;
            next_s.rdPend    = 1'b0;
            next_s.frameCrc  = cmcrc_pkg::CRC_INIT;
            next_s.statusN   = 1'b1;
            next_s.softError = 1'b0;
            next_s.signature = cmcrc_pkg::SIG_CLEAR;
        end
        next_s.tdo = next_s.reference[0];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s <= '{mode: cmcrc_pkg::CMCRC_CONFIG, wrAddr: '0, lastAddr: '0, rdAddr: '0,
                   rdPend: 1'b0, rdLast: 1'b0, frameCrc: cmcrc_pkg::CRC_INIT,
                   scanCrc: cmcrc_pkg::CRC_INIT, reference: cmcrc_pkg::REF_RESET,
                   signature: cmcrc_pkg::SIG_CLEAR, softError: 1'b0, statusN: 1'b1,
                   tdo: 1'b0, sy1: cmcrc_pkg::SY_RESET, sy2: cmcrc_pkg::SY_RESET,
                   sy3: cmcrc_pkg::SY_RESET, lvl: cmcrc_pkg::SY_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign jtagTdo       = s.tdo;
    assign jtagTdoOe     = shiftEn;
    assign configStatusN = s.statusN;
    assign userMode      = (s.mode == cmcrc_pkg::CMCRC_USER);
    assign softError     = s.softError;
    assign signature     = s.signature;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    frame_bad_a: assert property (
        cfgTake && cfgFrameEnd && !cfgStreamEnd && frameBad && s.lvl[cmcrc_pkg::SY_RECONF]
        |=> !configStatusN && s.mode == cmcrc_pkg::CMCRC_FAIL
            ##1 (!configStatusN || !$past(s.lvl[cmcrc_pkg::SY_RECONF])))
        else $error("frame crc mismatch did not stop configuration");
    frame_good_a: assert property (
        cfgTake && cfgFrameEnd && !cfgStreamEnd && !frameBad && s.lvl[cmcrc_pkg::SY_RECONF]
        |=> configStatusN && s.mode == cmcrc_pkg::CMCRC_CONFIG
            && s.frameCrc == cmcrc_pkg::CRC_INIT)
        else $error("good frame disturbed configuration");
    ref_latch_a: assert property (
        cfgTake && cfgStreamEnd && s.lvl[cmcrc_pkg::SY_RECONF]
        |=> userMode && s.reference == $past(cfgData))
        else $error("reference not stored at configuration end");
    scan_step_a: assert property (
        userMode && s.lvl[cmcrc_pkg::SY_RECONF] && s.rdAddr != s.lastAddr
        |=> s.rdAddr == ADDR_W'($past(s.rdAddr) + 1'b1) && s.rdPend)
        else $error("user scan stalled");
    scan_keep_a: assert property (
        userMode && s.lvl[cmcrc_pkg::SY_RECONF] |=> userMode)
        else $error("user checking stopped without reconfiguration");
    reconf_exit_a: assert property (
        !s.lvl[cmcrc_pkg::SY_RECONF] |=> !userMode && configStatusN && !softError)
        else $error("reconfiguration request ignored");
    sig_flag_a: assert property (
        softError == (signature != cmcrc_pkg::SIG_CLEAR))
        else $error("soft error disagrees with signature");
    flag_hold_a: assert property (
        !passEnd && s.lvl[cmcrc_pkg::SY_RECONF] |=> $stable(softError) && $stable(signature))
        else $error("soft error moved inside a pass");
    ref_shift_a: assert property (
        tckRise && shiftEn && s.lvl[cmcrc_pkg::SY_RECONF]
        |=> s.reference == {$past(s.lvl[cmcrc_pkg::SY_TDI]), $past(s.reference[31:1])}
            ##1 jtagTdo == $past(s.reference[0]))
        else $error("reference scan shift wrong");
    ref_lock_a: assert property (
        !userMode && !(cfgTake && cfgStreamEnd) |=> $stable(s.reference))
        else $error("reference changed outside user mode");
    fail_hold_a: assert property (
        s.mode == cmcrc_pkg::CMCRC_FAIL && s.lvl[cmcrc_pkg::SY_RECONF]
        |=> s.mode == cmcrc_pkg::CMCRC_FAIL && !configStatusN)
        else $error("configuration resumed after a frame mismatch");
    fail_nowrite_a: assert property (
        s.mode == cmcrc_pkg::CMCRC_FAIL && s.lvl[cmcrc_pkg::SY_RECONF] |=> $stable(s.wrAddr))
        else $error("cells still written after a frame mismatch");
    scan_wrap_a: assert property (
        userMode && s.lvl[cmcrc_pkg::SY_RECONF] && s.rdAddr == s.lastAddr
        |=> s.rdAddr == '0 && s.rdLast)
        else $error("user scan did not wrap at the last cell");
    tdo_bit_a: assert property (
        jtagTdoOe |-> jtagTdo == s.reference[0])
        else $error("scan output not the reference lsb");

    enter_user_c: cover property (cfgTake && cfgStreamEnd ##1 userMode);
    frame_fail_c: cover property (cfgTake && cfgFrameEnd && frameBad ##1 !configStatusN);
    inject_c:     cover property (tckRise && shiftEn);
    soft_err_c:   cover property (passEnd ##1 softError);
endmodule

// ===== testbench/cmcrc_jtag_host.sv
// tester model that drives the load instruction and shifts the reference register
`timescale 1ns/1ns
module cmcrc_jtag_host (
    input  wire logic core_clk,
    input  wire logic jtagTdo,
    input  wire logic jtagTdoOe,
    output logic      jtagTck,
    output logic      jtagTdi,
    output logic      jtagShiftDr,
    output logic      loadReferenceInstr
);
    // tck levels stand well above the 3-cycle pin sync
    localparam int HALF = 8;

    initial begin
        jtagTck            = 1'b0;
        jtagTdi            = 1'b0;
        jtagShiftDr        = 1'b0;
        loadReferenceInstr = 1'b0;
    end

    task automatic hold();
        repeat (HALF) @(negedge core_clk);
    endtask

    // new value goes in lsb first while the old one comes out lsb first
    task automatic shift32(input logic [31:0] val, output logic [31:0] old,
                           output logic oeSeen);
        oeSeen = 1'b0;
        loadReferenceInstr = 1'b1;
        jtagShiftDr = 1'b1;
        for (int i = 0; i < 32; i++) begin
            jtagTdi = val[i];
            hold();
            old[i] = jtagTdo;
            oeSeen = oeSeen | jtagTdoOe;
            jtagTck = 1'b1;
            hold();
            jtagTck = 1'b0;
        end
        hold();
        loadReferenceInstr = 1'b0;
        jtagShiftDr = 1'b0;
        // no pull on tdi: show a changed level, not the last bit
        jtagTdi = ~jtagTdi;
    endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking testbench for the configuration memory crc checker
`timescale 1ns/1ns
module tb_top;
    localparam int CELLS = 16;
    localparam int WPF   = 4;

    logic        core_clk;
    logic        rst;
    logic        cfgValid;
    logic [31:0] cfgData;
    logic        cfgFrameEnd;
    logic        cfgStreamEnd;
    logic        reconfigRequestN;
    logic        loadReferenceInstr;
    logic        jtagTck;
    logic        jtagTdi;
    logic        jtagShiftDr;
    logic        jtagTdo;
    logic        jtagTdoOe;
    logic        configStatusN;
    logic        userMode;
    logic        softError;
    logic [31:0] signature;
    logic [31:0] goodRef;
    logic [31:0] old;
    logic        oeSeen;
    int          mismatches;
    int          nTests;

    cmcrc_checker #(.CELL_WORDS(CELLS)) u_cmcrc_checker (
        .core_clk(core_clk), .rst(rst), .cfgValid(cfgValid), .cfgData(cfgData),
        .cfgFrameEnd(cfgFrameEnd), .cfgStreamEnd(cfgStreamEnd),
        .reconfigRequestN(reconfigRequestN), .loadReferenceInstr(loadReferenceInstr),
        .jtagTck(jtagTck), .jtagTdi(jtagTdi), .jtagShiftDr(jtagShiftDr),
        .jtagTdo(jtagTdo), .jtagTdoOe(jtagTdoOe), .configStatusN(configStatusN),
        .userMode(userMode), .softError(softError), .signature(signature));

    cmcrc_jtag_host u_cmcrc_jtag_host (
        .core_clk(core_clk), .jtagTdo(jtagTdo), .jtagTdoOe(jtagTdoOe),
        .jtagTck(jtagTck), .jtagTdi(jtagTdi), .jtagShiftDr(jtagShiftDr),
        .loadReferenceInstr(loadReferenceInstr));

    always #2 core_clk = ~core_clk;

    // own copy of the crc so expectations never lean on the design
    function automatic logic [31:0] crcWord(input logic [31:0] c, input logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04c11db7 : 32'h00000000);
        end
        return c;
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && nTests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic word(input logic [31:0] d, input logic fe, input logic se);
        cfgValid = 1'b1;
        cfgData = d;
        cfgFrameEnd = fe;
        cfgStreamEnd = se;
        @(negedge core_clk);
    endtask

    // two frames of four words; spoil corrupts the second frame crc
    task automatic configure(input logic [15:0] spoil, output logic [31:0] whole);
        logic [31:0] fc;
        logic [31:0] d;
        whole = 32'hffffffff;
        for (int f = 0; f < 2; f++) begin
            fc = 32'hffffffff;
            for (int i = 0; i < WPF; i++) begin
                d = {8'h3c, 8'(f), 8'(i), 8'ha7};
                fc = crcWord(fc, d);
                whole = crcWord(whole, d);
                word(d, 1'b0, 1'b0);
            end
            word({16'h0000, fc[15:0] ^ (f == 1 ? spoil : 16'h0000)}, 1'b1, 1'b0);
        end
        word(whole, 1'b0, 1'b1);
        cfgValid = 1'b0;
        cfgFrameEnd = 1'b0;
        cfgStreamEnd = 1'b0;
        cfgData = ~cfgData;
        cycles(3);
    endtask

    task automatic t_good_config();
        configure(16'h0000, goodRef);
        chk("userMode", userMode, 1);
        chk("configStatusN", configStatusN, 1);
        cycles(30);
        chk("signature", signature, 0);
        chk("softError", softError, 0);
        chk("jtagTdoOe", jtagTdoOe, 0);
    endtask

    task automatic t_inject();
        u_cmcrc_jtag_host.shift32(goodRef ^ 32'h00000100, old, oeSeen);
        chk("readback", old, goodRef);
        chk("oeSeen", oeSeen, 1);
        cycles(30);
        chk("signature", signature, 32'h00000100);
        chk("softError", softError, 1);
        u_cmcrc_jtag_host.shift32(goodRef, old, oeSeen);
        chk("readback", old, goodRef ^ 32'h00000100);
        cycles(30);
        chk("softError", softError, 0);
    endtask

    task automatic t_reconfig();
        reconfigRequestN = 1'b0;
        cycles(10);
        chk("userMode", userMode, 0);
        reconfigRequestN = 1'b1;
        cycles(6);
        // load instruction outside user mode must be ignored
        u_cmcrc_jtag_host.shift32(32'hffffffff, old, oeSeen);
        chk("oeSeen", oeSeen, 0);
        configure(16'h0001, old);
        chk("configStatusN", configStatusN, 0);
        chk("userMode", userMode, 0);
    endtask

    task automatic t_power_cycle();
        rst = 1'b1;
        cycles(12);
        rst = 1'b0;
        chk("configStatusN", configStatusN, 1);
        chk("userMode", userMode, 0);
        chk("softError", softError, 0);
        chk("signature", signature, 0);
        configure(16'h0000, goodRef);
        cycles(30);
        chk("userMode", userMode, 1);
        chk("softError", softError, 0);
    endtask

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        cfgValid = 1'b0;
        cfgData = 32'h00000000;
        cfgFrameEnd = 1'b0;
        cfgStreamEnd = 1'b0;
        reconfigRequestN = 1'b1;
        mismatches = 0;
        nTests = 0;
        cycles(12);
        rst = 1'b0;
        t_good_config();
        t_inject();
        t_reconfig();
        t_power_cycle();
        give_verdict();
    end

    // whole run is under two thousand cycles; this leaves a wide margin
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule
